// ### hcg_pkg.sv
/*
 * Shared constants for the host command and pin handler: command codes,
 * payload limits, pin map, drive mode codes, register indices, rates.
 * Assumes a single 200 MHz clock and a framed byte stream from a receiver.
 */
`default_nettype none
package hcg_pkg;
    // command and answer codes
    localparam logic [7:0] CMD_TEXT = 8'h1F;
    localparam logic [7:0] CMD_BAUD = 8'h21;
    localparam logic [7:0] CMD_PSET = 8'h22;
    localparam logic [7:0] CMD_PGET = 8'h23;
    localparam logic [7:0] ACK_FLAG = 8'h40;
    localparam logic [7:0] PGET_LEN = 8'h04;
    // display geometry
    localparam logic [7:0] COL_LAST = 8'h13;
    localparam logic [7:0] ROW_LAST = 8'h03;
    localparam logic [7:0] COLS = 8'h14;
    localparam logic [7:0] TEXT_FIRST = 8'h02;
    // pin map: general pins 0..4, led dies 5..12
    localparam int NGPIO = 5;
    localparam int NPIN = 13;
    localparam logic [7:0] PIN_LAST = 8'h0C;
    localparam logic [7:0] GPIO_LAST = 8'h04;
    localparam logic [7:0] LVL_HIGH = 8'h64;
    // drive mode codes
    localparam logic [2:0] DM_UP_PD = 3'h0;
    localparam logic [2:0] DM_FAST = 3'h1;
    localparam logic [2:0] DM_HIZ = 3'h2;
    localparam logic [2:0] DM_PU_DN = 3'h3;
    localparam logic [2:0] DM_SUP_Z = 3'h4;
    localparam logic [2:0] DM_SLOW = 3'h5;
    localparam logic [2:0] DM_RSVD = 3'h6;
    localparam logic [2:0] DM_Z_SDN = 3'h7;
    localparam int FN_BIT = 3;
    // baud select values
    localparam logic BAUD_19200 = 1'b0;
    localparam logic BAUD_115200 = 1'b1;
    // reset values of pin configuration
    localparam logic [7:0] RST_VAL = 8'h00;
    localparam logic [2:0] RST_MODE = DM_HIZ;
    localparam logic RST_FN = 1'b0;
    // register indices on the plain port
    localparam logic [3:0] REG_PIN0 = 4'h0;
    localparam logic [3:0] REG_BAUD = 4'hD;
    localparam logic [3:0] REG_STAT = 4'hE;
    localparam logic [3:0] REG_CTRL = 4'hF;
    localparam int VAL_LSB = 0;
    localparam int CFG_LSB = 8;
    // timing: rates in Hz, counts in clock cycles
    localparam int CLK_HZ = 200_000_000;
    localparam int PWM_HZ = 100;
    localparam int PWM_STEPS = 100;
    localparam int PWM_STEP_CYC = CLK_HZ / (PWM_HZ * PWM_STEPS);
    localparam int SAMPLE_HZ = 32;
    localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    localparam int CNT_W = 23;
endpackage
`default_nettype wire

// ### hcg_handler.sv
/*
 * Command interpreter for text placement, baud change, pin set and pin read.
 * Assumes a receiver that has checked framing and passes type, length and
 * payload bytes in order, a transmitter that adds framing to the answer
 * bytes and reports idle, and an external display memory of 4 rows x 20.
 */
// The address-and-strobe port and the register offsets were decided locally.
`default_nettype none
// How it works
// - text command 0x1F, column 0-19, row 0-3
// - text bytes written from column onward
// - answer type is command OR 0x40, empty
// - baud command 0x21, 0=19200, 1=115200
// - acknowledge sent first, then rate switches
// - link starts at 115200 unless boot restores
// - pin set 0x22, 2 or 3 bytes
// - level 0 low, 1-99 PWM, 100 high
// - drive modes 000 to 011 as listed
// - modes 100,101,111; 110 reserved
// - function bit selects user or default owner
// - pins sampled at 32 Hz
// - rise and fall latched between host reads
// - pin read 0x23, index 0-4, 4-byte reply
// - reply byte 1 holds rise, fall, level
// - reported level is the sampled pin
// - reply returns stored level and config
// - config, baud and text are saveable state
module hcg_handler
    import hcg_pkg::*;
#(
    parameter int PWM_STEP = PWM_STEP_CYC,
    parameter int SAMPLE_PERIOD = SAMPLE_CYC
) (
    input wire logic clock,
    input wire logic nrst,
    // command byte stream from the receiver
    input wire logic req_valid,
    input wire logic [7:0] req_byte,
    output logic req_ready,
    // answer byte stream to the transmitter
    output logic rsp_valid,
    output logic [7:0] rsp_byte,
    output logic rsp_last,
    input wire logic rsp_ready,
    input wire logic tx_idle,
    output logic baud_sel,
    // boot state restore of the link rate
    input wire logic boot_load,
    input wire logic boot_baud,
    // display write port
    output logic disp_we,
    output logic [6:0] disp_addr,
    output logic [7:0] disp_char,
    // general pins and led dies
    input wire logic [4:0] pin_i,
    input wire logic [4:0] dflt_o,
    output logic [4:0] pin_o,
    output logic [4:0] pin_oe,
    output logic [4:0] pin_pu,
    output logic [4:0] pin_pd,
    output logic [4:0] pin_slow,
    output logic [7:0] led_die_output,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata
);
    typedef enum logic [2:0] {
        ST_TYPE, ST_LEN, ST_DATA, ST_EXEC, ST_RSP, ST_BAUD
    } hcg_state_e;

    hcg_state_e state_q;
    logic [7:0] type_q, len_q, cnt_q, b0_q, b1_q, b2_q;
    logic [7:0] rsp_buf_q [0:5];
    logic [2:0] rsp_idx_q, rsp_end_q;
    logic [7:0] val_q [0:NPIN-1];
    logic [2:0] mode_q [0:NPIN-1];
    logic [NPIN-1:0] fn_q;
    logic [4:0] sync1_q, sync2_q, samp_q, rise_q, fall_q;
    logic [4:0] rd_clr;
    logic sample_en_q, pwm_tick, samp_tick, new_baud_q, primed_q;
    logic [CNT_W-1:0] pwm_pre_q, samp_pre_q;
    logic [6:0] pwm_cnt_q;
    logic [NPIN-1:0] lvl;
    logic take, rsp_take, text_ok, pset_ok;
    logic [7:0] pidx;

    assign take = req_valid && req_ready;
    assign rsp_take = rsp_valid && rsp_ready;
    assign req_ready = (state_q == ST_TYPE) || (state_q == ST_LEN)
        || (state_q == ST_DATA);
    assign rsp_valid = (state_q == ST_RSP);
    assign rsp_last = (state_q == ST_RSP) && (rsp_idx_q == rsp_end_q);
    assign pidx = b0_q;
    // coordinates checked before any character is written
    assign text_ok = (b0_q <= COL_LAST) && (b1_q <= ROW_LAST);
    assign pset_ok = (pidx <= PIN_LAST)
        && (b1_q <= LVL_HIGH);

    // command byte collection; payload length sets the end of a packet
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_TYPE;
            type_q <= 8'h00;
            len_q <= 8'h00;
            cnt_q <= 8'h00;
            b0_q <= 8'h00;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
            rsp_idx_q <= 3'h0;
            rsp_end_q <= 3'h0;
            new_baud_q <= BAUD_115200;
        end else begin
            unique case (state_q)
                ST_TYPE: if (take) begin
                    type_q <= req_byte;
                    state_q <= ST_LEN;
                end
                ST_LEN: if (take) begin
                    len_q <= req_byte;
                    cnt_q <= 8'h00;
                    state_q <= (req_byte == 8'h00) ? ST_EXEC : ST_DATA;
                end
                ST_DATA: if (take) begin
                    if (cnt_q == 8'h00) b0_q <= req_byte;
                    if (cnt_q == 8'h01) b1_q <= req_byte;
                    if (cnt_q == 8'h02) b2_q <= req_byte;
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q + 8'h01 == len_q) state_q <= ST_EXEC;
                end
                ST_EXEC: begin
                    // empty acknowledge unless a read reply follows
                    rsp_idx_q <= 3'h0;
                    rsp_end_q <= (type_q == CMD_PGET) ? 3'h5 : 3'h1;
                    new_baud_q <= b0_q[0];
                    if (type_q == CMD_TEXT || type_q == CMD_BAUD
                        || type_q == CMD_PSET || type_q == CMD_PGET) begin
                        state_q <= ST_RSP;
                    end else begin
                        // other commands belong to other handlers
                        state_q <= ST_TYPE;
                    end
                end
                ST_RSP: if (rsp_take) begin
                    rsp_idx_q <= rsp_idx_q + 3'h1;
                    if (rsp_last) begin
                        // the rate may only move after the ack left
                        state_q <= (type_q == CMD_BAUD && len_q == 8'h01
                            && b0_q <= 8'h01) ? ST_BAUD : ST_TYPE;
                    end
                end
                ST_BAUD: if (tx_idle) state_q <= ST_TYPE;
                default: state_q <= ST_TYPE;
            endcase
        end
    end

    // answer bytes are built once and then stepped through
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 6; i++) rsp_buf_q[i] <= 8'h00;
            rsp_byte <= 8'h00;
        end else if (state_q == ST_EXEC) begin
            rsp_buf_q[0] <= type_q | ACK_FLAG;
            rsp_buf_q[1] <= (type_q == CMD_PGET) ? PGET_LEN : 8'h00;
            rsp_buf_q[2] <= pidx;
            rsp_buf_q[3] <= 8'h00;
            rsp_buf_q[4] <= 8'h00;
            rsp_buf_q[5] <= 8'h00;
            if (pidx <= GPIO_LAST) begin
                // level is the sampled pin, not the request
                rsp_buf_q[3] <= {5'h00, rise_q[pidx[2:0]],
                    fall_q[pidx[2:0]], samp_q[pidx[2:0]]};
                rsp_buf_q[4] <= val_q[pidx[3:0]];
                rsp_buf_q[5] <= {4'h0, fn_q[pidx[3:0]],
                    mode_q[pidx[3:0]]};
            end
            rsp_byte <= type_q | ACK_FLAG;
        end else if (rsp_take && !rsp_last) begin
            rsp_byte <= rsp_buf_q[rsp_idx_q + 3'h1];
        end
    end

    // text goes straight to the display as it arrives
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            disp_we <= 1'b0;
            disp_addr <= 7'h00;
            disp_char <= 8'h00;
        end else begin
            disp_we <= 1'b0;
            if (take && state_q == ST_DATA && type_q == CMD_TEXT
                && cnt_q >= TEXT_FIRST && text_ok
                && b0_q + cnt_q - TEXT_FIRST <= COL_LAST) begin
                disp_we <= 1'b1;
                disp_addr <= 7'(b1_q * COLS + b0_q + cnt_q - TEXT_FIRST);
                disp_char <= req_byte;
            end
        end
    end

    // link rate: fixed default at reset, boot state may override
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            baud_sel <= BAUD_115200;
        end else if (boot_load) begin
            baud_sel <= boot_baud;
        end else if (state_q == ST_BAUD && tx_idle) begin
            baud_sel <= new_baud_q;
        end else if (reg_wr && reg_addr == REG_BAUD) begin
            baud_sel <= reg_wdata[0];
        end
    end

    // pin configuration; the register port lets boot state reload it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NPIN; i++) begin
                val_q[i] <= RST_VAL;
                mode_q[i] <= RST_MODE;
            end
            fn_q <= {NPIN{RST_FN}};
        end else if (state_q == ST_EXEC && type_q == CMD_PSET && pset_ok) begin
            if (len_q == 8'h02 || len_q == 8'h03) begin
                val_q[pidx[3:0]] <= b1_q;
            end
            if (len_q == 8'h03) begin
                // upper bits are dropped; host keeps them zero
                mode_q[pidx[3:0]] <= b2_q[2:0];
                fn_q[pidx[3:0]] <= b2_q[FN_BIT];
            end
        end else if (reg_wr && reg_addr <= PIN_LAST[3:0]) begin
            val_q[reg_addr] <= reg_wdata[VAL_LSB +: 8];
            mode_q[reg_addr] <= reg_wdata[CFG_LSB +: 3];
            fn_q[reg_addr] <= reg_wdata[CFG_LSB + FN_BIT];
        end
    end

    // pwm divider: one step per tick, 100 steps per period
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pwm_pre_q <= '0;
            pwm_cnt_q <= 7'h00;
        end else if (pwm_tick) begin
            pwm_pre_q <= '0;
            pwm_cnt_q <= (pwm_cnt_q == 7'(PWM_STEPS - 1)) ? 7'h00
                : pwm_cnt_q + 7'h01;
        end else begin
            pwm_pre_q <= pwm_pre_q + CNT_W'(1);
        end
    end
    assign pwm_tick = (pwm_pre_q == CNT_W'(PWM_STEP - 1));

    // requested level per pin; user function or default owner
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (val_q[i] == 8'h00) lvl[i] = 1'b0;
            else if (val_q[i] >= LVL_HIGH) lvl[i] = 1'b1;
            else lvl[i] = (8'(pwm_cnt_q) < val_q[i]);
            if (i < NGPIO && !fn_q[i]) lvl[i] = dflt_o[i];
        end
    end

    // drive decode; reserved mode floats the pin as a safe fallback
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pin_o <= 5'h00;
            pin_oe <= 5'h00;
            pin_pu <= 5'h00;
            pin_pd <= 5'h00;
            pin_slow <= 5'h00;
            led_die_output <= 8'h00;
        end else begin
            led_die_output <= lvl[NPIN-1:NGPIO];
            for (int i = 0; i < NGPIO; i++) begin
                pin_o[i] <= lvl[i];
                pin_oe[i] <= 1'b0;
                pin_pu[i] <= 1'b0;
                pin_pd[i] <= 1'b0;
                pin_slow[i] <= 1'b0;
                unique case (mode_q[i])
                    DM_UP_PD: begin
                        pin_oe[i] <= lvl[i];
                        pin_pd[i] <= !lvl[i];
                    end
                    DM_FAST: pin_oe[i] <= 1'b1;
                    DM_HIZ: pin_oe[i] <= 1'b0;
                    DM_PU_DN: begin
                        pin_oe[i] <= !lvl[i];
                        pin_pu[i] <= lvl[i];
                    end
                    DM_SUP_Z: begin
                        pin_oe[i] <= lvl[i];
                        pin_slow[i] <= 1'b1;
                    end
                    DM_SLOW: begin
                        pin_oe[i] <= 1'b1;
                        pin_slow[i] <= 1'b1;
                    end
                    DM_RSVD: pin_oe[i] <= 1'b0;
                    DM_Z_SDN: begin
                        pin_oe[i] <= !lvl[i];
                        pin_slow[i] <= 1'b1;
                    end
                endcase
            end
        end
    end

    // two-stage synchroniser on the pins before any sampling
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
        end
    end

    // 32 Hz sample strobe, runs regardless of commands
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) samp_pre_q <= '0;
        else if (samp_tick || !sample_en_q) samp_pre_q <= '0; // no wrap
        else samp_pre_q <= samp_pre_q + CNT_W'(1);
    end
    assign samp_tick = sample_en_q
        && (samp_pre_q == CNT_W'(SAMPLE_PERIOD - 1));

    // edge flags: a new edge in the clearing cycle is kept
    always_comb begin
        rd_clr = 5'h00;
        if (state_q == ST_EXEC && type_q == CMD_PGET
            && pidx <= GPIO_LAST) begin
            rd_clr[pidx[2:0]] = 1'b1;
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            samp_q <= 5'h00;
            rise_q <= 5'h00;
            fall_q <= 5'h00;
            primed_q <= 1'b0;
        end else begin
            if (samp_tick) samp_q <= sync2_q;
            // a pin idling high must not look like a rise after reset
            if (samp_tick) primed_q <= 1'b1;
            for (int i = 0; i < NGPIO; i++) begin
                if (samp_tick && primed_q && sync2_q[i] && !samp_q[i])
                    rise_q[i] <= 1'b1;
                else if (rd_clr[i])
                    rise_q[i] <= 1'b0;
                if (samp_tick && primed_q && !sync2_q[i] && samp_q[i])
                    fall_q[i] <= 1'b1;
                else if (rd_clr[i])
                    fall_q[i] <= 1'b0;
            end
        end
    end

    // control: sampling enable, on by default
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) sample_en_q <= 1'b1;
        else if (reg_wr && reg_addr == REG_CTRL) sample_en_q <= reg_wdata[0];
    end

    // register reads answer one cycle later; unmapped reads give zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                if (reg_addr <= PIN_LAST[3:0]) begin
                    reg_rdata <= {4'h0, fn_q[reg_addr], mode_q[reg_addr],
                        val_q[reg_addr]};
                end else if (reg_addr == REG_BAUD) begin
                    reg_rdata <= {15'h0000, baud_sel};
                end else if (reg_addr == REG_STAT) begin
                    reg_rdata <= {1'b0, rise_q, fall_q, samp_q};
                end else if (reg_addr == REG_CTRL) begin
                    reg_rdata <= {15'h0000, sample_en_q};
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### hcg_properties.sv
/* port checker for hcg_handler: answer framing, strobes, drive.
   assumes bind onto hcg_handler, one clock, nrst async active low. */
`default_nettype none
module hcg_properties
    import hcg_pkg::*;
#(
    parameter int PWM_STEP = 2,
    parameter int SAMPLE_PERIOD = 16
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_byte,
    input wire logic rsp_last,
    input wire logic rsp_ready,
    input wire logic tx_idle,
    input wire logic baud_sel,
    input wire logic boot_load,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic disp_we,
    input wire logic [6:0] disp_addr,
    input wire logic [4:0] pin_oe,
    input wire logic [4:0] pin_pu,
    input wire logic [4:0] pin_pd
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] pos_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // byte position inside the current answer
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) pos_q <= 3'h0;
        else if (rsp_valid && rsp_ready)
            pos_q <= rsp_last ? 3'h0 : pos_q + 3'h1;
    end
    a_ack_type: assert property (rsp_valid && pos_q == 3'h0 |->
        rsp_byte inside {8'h5F, 8'h61, 8'h62, 8'h63})
        else $error("bad answer type");
    a_ack_len: assert property (rsp_valid && pos_q == 3'h1 |->
        (rsp_byte == 8'h00 && rsp_last) || (rsp_byte == 8'h04 && !rsp_last))
        else $error("bad answer length");
    a_last_pos: assert property (rsp_valid && rsp_last |->
        pos_q == 3'h1 || pos_q == 3'h5) else $error("answer ends early");
    a_rsp_hold: assert property (rsp_valid && !rsp_ready |=>
        rsp_valid && $stable(rsp_byte) && $stable(rsp_last))
        else $error("answer byte dropped");
    a_busy_refuse: assert property (rsp_valid |-> !req_ready)
        else $error("request taken while answering");
    a_baud_late: assert property ($changed(baud_sel)
        && !$past(boot_load) && !$past(reg_wr)
        |-> $past(tx_idle) && !$past(req_ready))
        else $error("rate changed before ack sent");
    a_disp_range: assert property (disp_we |-> disp_addr <= 7'h4F)
        else $error("display address out of range");
    a_reg_quiet: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
    a_pull_excl: assert property ((pin_pu & pin_pd) == 5'h00 &&
        (pin_oe & (pin_pu | pin_pd)) == 5'h00) else $error("drive clash");
endmodule
bind hcg_handler hcg_properties #(
    .PWM_STEP(PWM_STEP), .SAMPLE_PERIOD(SAMPLE_PERIOD)
) u_props (.*);
`default_nettype wire

// ### hcg_host_model.sv
/* host side: offers queued command bytes, takes answers with random
   stalls, reports idle a few cycles after the last taken byte. */
`default_nettype none
module hcg_host_model (
    input wire logic clock,
    output logic req_valid,
    output logic [7:0] req_byte,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_byte,
    output logic rsp_ready,
    output logic tx_idle
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    logic [2:0] busy_q;
    initial begin
        req_valid = 1'b0;
        req_byte = 8'h00;
        rsp_ready = 1'b0;
        busy_q = 3'h0;
    end
    assign tx_idle = busy_q == 3'h0;
    // byte held until taken; bench queues a packet only after the
    // previous answer is in, so rate switch follows the ack
    always @(posedge clock) begin
        if (req_valid && req_ready) void'(txq.pop_front());
        if (txq.size() > 0) begin
            req_valid <= 1'b1;
            req_byte <= txq[0];
        end else begin
            req_valid <= 1'b0;
            req_byte <= ~req_byte; // released: no stale value
        end
        rsp_ready <= ($urandom % 3) != 0;
        if (rsp_valid && rsp_ready) begin
            rxq.push_back(rsp_byte);
            busy_q <= 3'h5;
        end else if (busy_q != 3'h0) begin
            busy_q <= busy_q - 3'h1;
        end
    end
endmodule
`default_nettype wire

// ### hcg_handler_test.sv
/* self-checking bench for hcg_handler against the host model.
   assumes short pwm step (2) and sample period (16) for speed. */
`default_nettype none
module hcg_handler_test
    import hcg_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, nrst, req_valid, req_ready, rsp_valid, rsp_last, rsp_ready;
    logic tx_idle, baud_sel, boot_load, boot_baud, disp_we, reg_wr, reg_rd;
    logic [7:0] req_byte, rsp_byte, disp_char, led_die_output;
    logic [6:0] disp_addr;
    logic [4:0] pin_i, dflt_o, pin_o, pin_oe, pin_pu, pin_pd, pin_slow;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [14:0] dq[$];
    int err_count = 0;
    int checks = 0;
    int pv[13];
    int pc[13];
    hcg_handler #(.PWM_STEP(2), .SAMPLE_PERIOD(16)) u_hcg_handler (.*);
    hcg_host_model u_hcg_host_model (.*);
    // 200 MHz
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // display writes seen, as {addr, char}
    always @(posedge clock) if (disp_we) dq.push_back({disp_addr, disp_char});
    // hang guard, well past the expected run
    initial begin
        #200000;
        err_count++;
        finish_test();
    end
    task automatic finish_test();
        if (err_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // queue one packet, wait for n answer bytes, then 8 more cycles
    task automatic pkt(input logic [7:0] b[$], input int n);
        int t;
        t = 0;
        u_hcg_host_model.rxq.delete();
        foreach (b[i]) u_hcg_host_model.txq.push_back(b[i]);
        while (u_hcg_host_model.rxq.size() < n && t < 3000) begin
            @(posedge clock);
            t++;
        end
        if (t == 3000) chk("reply count", 16'(n), 16'h0000);
        repeat (8) @(posedge clock);
    endtask
    task automatic ack(input logic [7:0] b[$]);
        pkt(b, 2);
        chk("ack type", {8'h00, b[0] | ACK_FLAG},
            16'(u_hcg_host_model.rxq[0]));
        chk("ack len", 16'h0000, 16'(u_hcg_host_model.rxq[1]));
    endtask
    task automatic text(input int c, r, n);
        logic [7:0] b[$];
        int k;
        b = '{CMD_TEXT, 8'(n + 2), 8'(c), 8'(r)};
        for (int i = 0; i < n; i++) b.push_back(8'($urandom_range(32, 126)));
        dq.delete();
        ack(b);
        k = 0;
        for (int i = 0; i < n; i++) begin
            if (c + i < 20 && r < 4) begin
                chk("disp", {1'b0, 7'(r * 20 + c + i), b[4 + i]},
                    16'(dq[k]));
                k++;
            end
        end
        chk("disp count", 16'(k), 16'(dq.size()));
    endtask
    task automatic pset(input int p, v, cfg, input bit cf);
        logic [7:0] b[$];
        b = '{CMD_PSET, cf ? 8'h03 : 8'h02, 8'(p), 8'(v)};
        if (cf) b.push_back(8'(cfg & 15)); // upper bits zero
        if (p < 13 && v <= 100) begin
            pv[p] = v;
            if (cf) pc[p] = cfg & 15;
        end
        ack(b);
    endtask
    task automatic pread(input int p, input logic [7:0] st);
        logic [7:0] e[$];
        e = '{CMD_PGET | ACK_FLAG, PGET_LEN, 8'(p), st, 8'h00, 8'h00};
        if (p < 5) e[4] = 8'(pv[p]);
        if (p < 5) e[5] = 8'(pc[p]);
        pkt('{CMD_PGET, 8'h01, 8'(p)}, 6);
        foreach (e[i]) begin
            chk("read", 16'(e[i]), 16'(u_hcg_host_model.rxq[i]));
        end
    endtask
    task automatic rrd(input logic [3:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        chk("reg", exp, reg_rdata);
    endtask
    task automatic rwr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // {oe, o, pu, pd, slow} per drive mode and level
    function automatic logic [4:0] drv(input int m, input bit h);
        case (m)
            0: return h ? 5'h18 : 5'h02;
            1: return h ? 5'h18 : 5'h10;
            3: return h ? 5'h04 : 5'h10;
            4: return h ? 5'h19 : 5'h00;
            5: return h ? 5'h19 : 5'h11;
            7: return h ? 5'h00 : 5'h11;
            default: return 5'h00;
        endcase
    endfunction
    // main sequence
    initial begin
        int k;
        void'($urandom(32'hFC18));
        nrst = 1'b0;
        {boot_load, boot_baud, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        pin_i = 5'h00;
        dflt_o = 5'($urandom);
        foreach (pv[i]) pv[i] = 0;
        foreach (pc[i]) pc[i] = 2;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        chk("reset rate", 16'h0001, 16'(baud_sel));
        rrd(REG_PIN0, 16'h0200);
        text(0, 1, 3);
        text(19, 3, 2);
        text(0, 4, 1);
        text(20, 0, 1);
        text(0, 0, 20);
        ack('{CMD_BAUD, 8'h01, 8'h00});
        chk("rate", 16'h0000, 16'(baud_sel));
        ack('{CMD_BAUD, 8'h01, 8'h01});
        chk("rate", 16'h0001, 16'(baud_sel));
        boot_load <= 1'b1;
        @(posedge clock);
        boot_load <= 1'b0;
        @(posedge clock);
        chk("boot rate", 16'h0000, 16'(baud_sel));
        ack('{CMD_BAUD, 8'h01, 8'h01});
        for (int m = 0; m < 8; m++) begin
            for (int h = 0; h < 2 && m != 6; h++) begin
                pset(0, h * 100, 8 + m, 1'b1);
                chk("drive", 16'(drv(m, h[0])), 16'({pin_oe[0],
                    pin_o[0] & pin_oe[0], pin_pu[0], pin_pd[0],
                    pin_slow[0] & pin_oe[0]}));
            end
        end
        pset(0, 100, 1, 1'b1);
        chk("default fn", 16'(dflt_o[0]), 16'(pin_o[0]));
        pset(0, 0, 0, 1'b0);
        for (int p = 5; p < 13; p++) pset(p, p[0] ? 100 : 0, 0, 1'b0);
        pset(13, 100, 0, 1'b0);
        pset(1, 101, 9, 1'b1);
        chk("led dies", 16'h0055, 16'(led_die_output));
        pset(1, 50, 9, 1'b1);
        k = 0;
        repeat (200) begin
            @(posedge clock);
            k += int'(pin_o[1]);
        end
        chk("pwm high", 16'h0064, 16'(k));
        pin_i <= 5'h04;
        repeat (40) @(posedge clock);
        pin_i <= 5'h00;
        repeat (40) @(posedge clock);
        pin_i <= 5'h04;
        repeat (40) @(posedge clock);
        pread(2, 8'h07);
        pread(2, 8'h01);
        pread(0, 8'h00);
        pset(1, 100, 11, 1'b1);
        pread(1, 8'h00);
        pread(7, 8'h00);
        rwr(4'h3, 16'h0B64);
        pv[3] = 100;
        pc[3] = 11;
        rrd(4'h3, 16'h0B64);
        rwr(REG_STAT, 16'hFFFF);
        rrd(REG_STAT, 16'h0004);
        rrd(REG_BAUD, 16'h0001);
        rwr(REG_BAUD, 16'h0000);
        rrd(REG_BAUD, 16'h0000);
        rwr(REG_CTRL, 16'h0000);
        rrd(REG_CTRL, 16'h0000);
        rwr(REG_CTRL, 16'h0001);
        rrd(REG_CTRL, 16'h0001);
        pread(3, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
